// File: common/sac_map.vh
// register map, field positions, reset values and timing counts for the converter control
// assumes a 10 MHz aclk and an AXI4-Lite master with 32-bit data
//
// How it works
// R1 - result msbs high byte, two lsbs low[7:6]
// R2 - result held until next conversion completes
// R3 - result bytes survive reset
// R4 - mode register resets to 30 hex
// R5 - mode bit7 picks 62 or 31 cycles
// R6 - mode bit6 gates trigger pin starts
// R7 - trigger polarity from edge select register
// R8 - mode bits 5,4 read one, ignore writes
// R9 - channel field decodes to inputs 0-11
// R10 - software changes channel only while idle
// R11 - software one or trigger edge starts conversion
// R12 - completion loads result and clears flag together
// R13 - start flag reads one while converting
// R14 - writing zero to flag aborts conversion
// R15 - start bits 6-0 read one, reset 7F
// R16 - clock stop bit4 low means standby
// R17 - completion sets request, enable gates interrupt
// R18 - software waits 10 clocks after standby release
// R19 - software reads result only while idle
// R20 - trigger during conversion leaves it undisturbed
`ifndef SAC_MAP_VH
`define SAC_MAP_VH

`define SAC_ADDR_W 20
// register indices; byte address is four times the index
`define SAC_IDX_RES_HIGH 16'hFFC4
`define SAC_IDX_RES_LOW 16'hFFC5
`define SAC_IDX_MODE 16'hFFC6
`define SAC_IDX_START 16'hFFC7
`define SAC_IDX_CLK_STOP 16'hFFFA
`define SAC_IDX_EDGE_SEL 16'hFFF2
`define SAC_IDX_IRQ 16'hFFF6

`define SAC_MODE_RESET 8'h30
`define SAC_MODE_SPEED_BIT 7
`define SAC_MODE_TRIG_BIT 6
`define SAC_MODE_FIXED 8'h30
`define SAC_START_FIXED 8'h7F
`define SAC_START_FLAG_BIT 7
`define SAC_CLK_STOP_RESET 8'hFF
`define SAC_STANDBY_BIT 4
`define SAC_EDGE_SEL_RESET 8'h00
`define SAC_EDGE_BIT 4
`define SAC_IRQ_REQ_BIT 0
`define SAC_IRQ_EN_BIT 1

`define SAC_CLK_HZ 10000000
`define SAC_CONV_SLOW 62
`define SAC_CONV_FAST 31
`define SAC_STANDBY_WAIT 10

`define SAC_RESP_OKAY 2'h0
`define SAC_RESP_SLVERR 2'h2

`endif

// File: core/sac_trig_edge.v
// synchroniser and edge detector for the external trigger pin
// assumes the pin is asynchronous to aclk
`timescale 1ns/1ps
module sac_trig_edge (
	input wire aclk,
	input wire aresetn,
	input wire pin,
	input wire rising_sel,
	output wire edge_pulse
);
	reg meta_reg;
	reg sync_reg;
	reg last_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= pin;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	// polarity comes from bit 4 of the edge select register held in the control top
	assign edge_pulse = rising_sel ? (sync_reg & ~last_reg) : (~sync_reg & last_reg); // R7
endmodule

// File: core/sac_conv_timer.v
// conversion period counter; done pulses on the last cycle of a period
// assumes start is ignored while busy and abort wins over everything
`timescale 1ns/1ps
module sac_conv_timer #(
	parameter CNT_W = 7
) (
	input wire aclk,
	input wire aresetn,
	input wire run_en,
	input wire start,
	input wire abort,
	input wire [CNT_W-1:0] period,
	output wire busy,
	output wire done
);
	reg busy_reg;
	reg [CNT_W-1:0] cnt_reg;

	assign busy = busy_reg;
	assign done = busy_reg & run_en & ~abort & (cnt_reg == period - {{(CNT_W-1){1'b0}}, 1'b1});

	always @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= {CNT_W{1'b0}};
		end else if (abort) begin
			busy_reg <= 1'b0;
			cnt_reg <= {CNT_W{1'b0}};
		end else if (done) begin
			busy_reg <= 1'b0;
			cnt_reg <= {CNT_W{1'b0}};
		end else if (busy_reg) begin
			// standby freezes the count rather than losing it
			if (run_en)
				cnt_reg <= cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
		end else if (start) begin
			busy_reg <= 1'b1;
			cnt_reg <= {CNT_W{1'b0}};
		end
	end
endmodule

// File: core/sac_adc_ctrl.v
// converter control top: AXI4-Lite register slave, start logic, result capture
// assumes the analog macro presents its 10-bit code on conv_raw at the end of the period
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_adc_ctrl (
	input wire aclk,
	input wire aresetn,
	input wire [`SAC_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output wire [1:0] s_axi_bresp,
	output wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`SAC_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0] s_axi_rresp,
	output wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire trigger_pin,
	input wire [9:0] conv_raw,
	output wire [3:0] analog_channel,
	output wire channel_valid,
	output wire converting,
	output wire conv_done_irq
);
	localparam CNT_W = 7;
	localparam [CNT_W-1:0] PERIOD_SLOW = `SAC_CONV_SLOW;
	localparam [CNT_W-1:0] PERIOD_FAST = `SAC_CONV_FAST;

	////////////////////////////////////////////////////////////////////////////////
	// registers
	reg [7:0] mode_reg;
	reg flag_reg;
	reg [7:0] clk_stop_reg;
	reg [7:0] edge_sel_reg;
	reg req_reg;
	reg irq_en_reg;
	reg [9:0] result_reg;

	reg bvalid_reg;
	reg [1:0] bresp_reg;
	reg rvalid_reg;
	reg [1:0] rresp_reg;
	reg [31:0] rdata_reg;

	wire standby_n = clk_stop_reg[`SAC_STANDBY_BIT]; // R16
	wire speed_fast = mode_reg[`SAC_MODE_SPEED_BIT];
	wire trig_en = mode_reg[`SAC_MODE_TRIG_BIT];
	wire [3:0] channel_field = mode_reg[3:0];

	////////////////////////////////////////////////////////////////////////////////
	// write channel: address and data are taken together
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
	wire [`SAC_ADDR_W-3:0] wr_idx = s_axi_awaddr[`SAC_ADDR_W-1:2];
	wire wr_lane0 = wr_go & s_axi_wstrb[0];
	wire [7:0] wbyte = s_axi_wdata[7:0];

	wire wr_mode = (wr_idx == `SAC_IDX_MODE);
	wire wr_start = (wr_idx == `SAC_IDX_START);
	wire wr_stop = (wr_idx == `SAC_IDX_CLK_STOP);
	wire wr_edge = (wr_idx == `SAC_IDX_EDGE_SEL);
	wire wr_irq = (wr_idx == `SAC_IDX_IRQ);
	wire wr_ro = (wr_idx == `SAC_IDX_RES_HIGH) | (wr_idx == `SAC_IDX_RES_LOW);
	wire wr_hit = wr_mode | wr_start | wr_stop | wr_edge | wr_irq | wr_ro;

	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg <= `SAC_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_reg <= 1'b1;
			bresp_reg <= wr_hit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// start, abort and trigger
	wire trig_edge;
	wire timer_busy;
	wire timer_done;

	sac_trig_edge u_trig (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin(trigger_pin),
		.rising_sel(edge_sel_reg[`SAC_EDGE_BIT]),
		.edge_pulse(trig_edge)
	);

	wire sw_set = wr_lane0 & wr_start & wbyte[`SAC_START_FLAG_BIT];
	wire sw_clear = wr_lane0 & wr_start & ~wbyte[`SAC_START_FLAG_BIT];
	wire hw_trig = trig_en & trig_edge & standby_n; // R6
	// a start in the completion cycle is dropped; a running conversion
	// is never restarted, so a late edge leaves the flag and the count alone
	wire start_req = (sw_set | hw_trig) & standby_n & ~timer_busy; // R11 R20
	wire abort_req = sw_clear; // R14

	sac_conv_timer #(
		.CNT_W(CNT_W)
	) u_timer (
		.aclk(aclk),
		.aresetn(aresetn),
		.run_en(standby_n),
		.start(start_req),
		.abort(abort_req),
		.period(speed_fast ? PERIOD_FAST : PERIOD_SLOW), // R5
		.busy(timer_busy),
		.done(timer_done)
	);

	always @(posedge aclk) begin
		if (!aresetn) begin
			flag_reg <= 1'b0;
		end else if (abort_req) begin
			flag_reg <= 1'b0; // R14
		end else if (start_req) begin
			flag_reg <= 1'b1; // R11
		end else if (timer_done) begin
			flag_reg <= 1'b0; // R12 R13
		end
	end

	// no reset: the last result outlives a reset
	always @(posedge aclk) begin
		if (timer_done)
			result_reg <= conv_raw; // R2 R3 R12
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers
	always @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= `SAC_MODE_RESET; // R4
			clk_stop_reg <= `SAC_CLK_STOP_RESET;
			edge_sel_reg <= `SAC_EDGE_SEL_RESET;
			irq_en_reg <= 1'b0;
		end else if (wr_lane0) begin
			if (wr_mode)
				mode_reg <= wbyte | `SAC_MODE_FIXED; // R8
			if (wr_stop)
				clk_stop_reg <= wbyte; // R16
			if (wr_edge)
				edge_sel_reg <= wbyte;
			if (wr_irq)
				irq_en_reg <= wbyte[`SAC_IRQ_EN_BIT];
		end
	end

	// request is sticky; completion wins over a software clear in the same cycle
	always @(posedge aclk) begin
		if (!aresetn)
			req_reg <= 1'b0;
		else if (timer_done)
			req_reg <= 1'b1; // R17
		else if (wr_lane0 & wr_irq & ~wbyte[`SAC_IRQ_REQ_BIT])
			req_reg <= 1'b0;
	end

	assign conv_done_irq = req_reg & irq_en_reg; // R17

	////////////////////////////////////////////////////////////////////////////////
	// read channel: answer one cycle after the address is taken
	wire [`SAC_ADDR_W-3:0] rd_idx = s_axi_araddr[`SAC_ADDR_W-1:2];
	wire rd_go = s_axi_arvalid & ~rvalid_reg;
	reg [7:0] rd_byte;
	reg rd_hit;

	always @* begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		case (rd_idx)
			`SAC_IDX_RES_HIGH: rd_byte = result_reg[9:2]; // R1
			`SAC_IDX_RES_LOW: rd_byte = {result_reg[1:0], 6'h00}; // R1
			`SAC_IDX_MODE: rd_byte = mode_reg | `SAC_MODE_FIXED; // R8
			`SAC_IDX_START: rd_byte = {flag_reg, 7'h00} | `SAC_START_FIXED; // R13 R15
			`SAC_IDX_CLK_STOP: rd_byte = clk_stop_reg;
			`SAC_IDX_EDGE_SEL: rd_byte = edge_sel_reg;
			`SAC_IDX_IRQ: rd_byte = {6'h00, irq_en_reg, req_reg};
			default: rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `SAC_RESP_OKAY;
		end else if (rd_go) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= {24'h000000, rd_byte};
			rresp_reg <= rd_hit ? `SAC_RESP_OKAY : `SAC_RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// analog side: upper pair 00 selects nothing
	reg [3:0] chan_reg;
	reg chan_valid_reg;
	always @(posedge aclk) begin
		if (!aresetn) begin
			chan_reg <= 4'h0;
			chan_valid_reg <= 1'b0;
		end else begin
			chan_reg <= {2'h0, channel_field[1:0]} + {channel_field[3:2] - 2'h1, 2'h0}; // R9
			chan_valid_reg <= (channel_field[3:2] != 2'h0); // R9
		end
	end

	assign analog_channel = chan_reg;
	assign channel_valid = chan_valid_reg;
	assign converting = flag_reg;
endmodule

// File: verification/sac_adc_monitor.sv
// port-level checker for the converter control top
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`include "sac_map.vh"
module sac_adc_monitor (
	input wire aclk,
	input wire aresetn,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_bvalid,
	input wire [1:0] s_axi_bresp,
	input wire [`SAC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire [31:0] s_axi_rdata,
	input wire converting,
	input wire channel_valid,
	input wire [3:0] analog_channel,
	input wire conv_done_irq
);
	reg [15:0] ridx_reg;
	wire [7:0] rb = s_axi_rdata[7:0];
	wire rv = s_axi_rvalid;
	// remembers which register the pending read answers
	always @(posedge aclk) begin
		if (s_axi_arvalid && s_axi_arready)
			ridx_reg <= s_axi_araddr[17:2];
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
		else $error("write answer late");
	aw_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while answer pending");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> rv)
		else $error("read answer late");
	mode_fixed_a: assert property (rv && ridx_reg == `SAC_IDX_MODE |-> rb[5:4] == 2'h3)
		else $error("mode fixed bits wrong");
	start_fixed_a: assert property (rv && ridx_reg == `SAC_IDX_START |-> rb[6:0] == 7'h7F)
		else $error("start fixed bits wrong");
	flag_busy_a: assert property (rv && ridx_reg == `SAC_IDX_START && converting
		&& $past(converting) |-> rb[7]) else $error("flag low while busy");
	low_pad_a: assert property (rv && ridx_reg == `SAC_IDX_RES_LOW |-> rb[5:0] == 6'h00)
		else $error("low result padding wrong");
	chan_range_a: assert property (channel_valid |-> analog_channel <= 4'hB)
		else $error("channel out of range");
	conv_span_a: assert property ($rose(converting) |-> converting [*8])
		else $error("conversion too short");
	rst_idle_a: assert property (disable iff (1'b0) !aresetn |=> !converting && !rv)
		else $error("busy after reset");
	cover property ($rose(converting));
	cover property ($fell(converting) && conv_done_irq);
	cover property (s_axi_bvalid && s_axi_bresp == `SAC_RESP_SLVERR);
endmodule
bind sac_adc_ctrl sac_adc_monitor u_sac_adc_monitor (.*);

// File: verification/sac_far_model.sv
// analog macro and trigger source in front of the converter control
// assumes the bench sets the code and the trigger level
`timescale 1ns/1ps
module sac_far_model (
	input wire aclk,
	input wire converting,
	input wire [9:0] code,
	input wire trig_lvl,
	output wire [9:0] conv_raw,
	output reg trigger_pin
);
	// code is only valid inside a conversion; idle shows the inverse
	assign conv_raw = converting ? code : ~code;
	always @(posedge aclk) begin
		trigger_pin <= trig_lvl;
	end
endmodule

// File: verification/test_sac_adc_ctrl.sv
// self-checking bench for the converter control top
// assumes the far-side model supplies the analog code and trigger pin
`timescale 1ns/1ps
`include "sac_map.vh"
module test_sac_adc_ctrl;
	reg aclk = 0;
	reg aresetn = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, trig = 0;
	reg s_axi_bready = 1, s_axi_rready = 1;
	reg [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg [19:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0;
	reg [9:0] code = 10'h2A5;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [9:0] conv_raw;
	wire [3:0] analog_channel;
	wire trigger_pin, channel_valid, converting, conv_done_irq;
	integer fail_count = 0, cmp_count = 0, n, t0, i;
	sac_adc_ctrl u_sac_adc_ctrl (.*);
	sac_far_model u_sac_far_model (.aclk(aclk), .converting(converting), .code(code),
		.trig_lvl(trig), .conv_raw(conv_raw), .trigger_pin(trigger_pin));
	task finish_test;
		begin
			$display("compares %0d mismatches %0d", cmp_count, fail_count);
			if (fail_count == 0 && cmp_count > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			cmp_count = cmp_count + 1;
			if (s !== e) begin
				fail_count = fail_count + 1;
				$display("BAD %0t seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task hang(input integer k);
		begin
			if (k >= 200) begin
				fail_count = fail_count + 1;
				finish_test;
			end
		end
	endtask
	task wr(input [15:0] x, input [7:0] d, input [1:0] e);
		begin
			s_axi_awaddr <= {x, 2'h0};
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1;
			s_axi_wvalid <= 1;
			n = 0;
			do begin
				@(posedge aclk);
				if (s_axi_awvalid && s_axi_awready) begin
					s_axi_awvalid <= 0;
					t0 = $time;
				end
				if (s_axi_wvalid && s_axi_wready)
					s_axi_wvalid <= 0;
				n = n + 1;
			end while (!s_axi_bvalid && n < 200);
			hang(n);
			chk(s_axi_bresp, e);
		end
	endtask
	task rdc(input [15:0] x, input [7:0] e);
		begin
			s_axi_araddr <= {x, 2'h0};
			s_axi_arvalid <= 1;
			n = 0;
			do begin
				@(posedge aclk);
				if (s_axi_arvalid && s_axi_arready)
					s_axi_arvalid <= 0;
				n = n + 1;
			end while (!s_axi_rvalid && n < 200);
			hang(n);
			chk(s_axi_rdata, {24'h0, e});
			chk(s_axi_rresp, `SAC_RESP_OKAY);
		end
	endtask
	// waits for the flag to drop; cycles counted from the start write
	task wdone(input integer exp);
		begin
			n = 0;
			do begin
				@(posedge aclk);
				#1;
				n = n + 1;
			end while (converting && n < 200);
			hang(n);
			if (exp > 0)
				chk(($time - 1 - t0) / 100, exp);
			@(posedge aclk);
		end
	endtask
	initial begin
		forever #50 aclk = ~aclk;
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rdc(`SAC_IDX_MODE, 8'h30);
		rdc(`SAC_IDX_START, 8'h7F);
		rdc(`SAC_IDX_CLK_STOP, 8'hFF);
		wr(16'hFF00, 8'h00, `SAC_RESP_SLVERR);
		for (i = 0; i < 16; i = i + 1) begin
			wr(`SAC_IDX_MODE, i[7:0], 0);
			repeat (2) @(posedge aclk);
			chk(channel_valid, i[3:2] != 0);
			if (i[3:2] != 0)
				chk(analog_channel, (i[3:2] - 1) * 4 + i[1:0]);
		end
		rdc(`SAC_IDX_MODE, 8'h3F);
		wr(`SAC_IDX_START, 8'h80, 0);
		rdc(`SAC_IDX_START, 8'hFF);
		wdone(62);
		rdc(`SAC_IDX_RES_HIGH, 8'hA9);
		rdc(`SAC_IDX_RES_LOW, 8'h40);
		wr(`SAC_IDX_IRQ, 8'h03, 0);
		chk(conv_done_irq, 1);
		wr(`SAC_IDX_IRQ, 8'h02, 0);
		chk(conv_done_irq, 0);
		wr(`SAC_IDX_MODE, 8'h80, 0);
		code <= 10'h0F3;
		wr(`SAC_IDX_START, 8'h80, 0);
		wdone(31);
		rdc(`SAC_IDX_IRQ, 8'h03);
		wr(`SAC_IDX_IRQ, 8'h02, 0);
		code <= 10'h155;
		wr(`SAC_IDX_START, 8'h80, 0);
		repeat (20) @(posedge aclk);
		wr(`SAC_IDX_START, 8'h00, 0);
		chk(converting, 0);
		rdc(`SAC_IDX_RES_HIGH, 8'h3C);
		rdc(`SAC_IDX_RES_LOW, 8'hC0);
		rdc(`SAC_IDX_IRQ, 8'h02);
		wr(`SAC_IDX_EDGE_SEL, 8'h10, 0);
		trig <= 1;
		repeat (8) @(posedge aclk);
		chk(converting, 0);
		trig <= 0;
		wr(`SAC_IDX_MODE, 8'hC0, 0);
		repeat (6) @(posedge aclk);
		trig <= 1;
		repeat (8) @(posedge aclk);
		chk(converting, 1);
		// start took hold four edges after trig rose: model flop, two sync flops, detect
		t0 = $time - 400;
		trig <= 0;
		repeat (4) @(posedge aclk);
		trig <= 1;
		repeat (6) @(posedge aclk);
		chk(converting, 1);
		wdone(31);
		wr(`SAC_IDX_EDGE_SEL, 8'h00, 0);
		trig <= 0;
		repeat (8) @(posedge aclk);
		chk(converting, 1);
		wdone(0);
		wr(`SAC_IDX_CLK_STOP, 8'hEF, 0);
		wr(`SAC_IDX_START, 8'h80, 0);
		repeat (2) @(posedge aclk);
		chk(converting, 0);
		wr(`SAC_IDX_CLK_STOP, 8'hFF, 0);
		repeat (10) @(posedge aclk);
		code <= 10'h3FF;
		wr(`SAC_IDX_START, 8'h80, 0);
		wdone(31);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rdc(`SAC_IDX_RES_HIGH, 8'hFF);
		rdc(`SAC_IDX_MODE, 8'h30);
		finish_test;
	end
endmodule
